// ===== rtl/gpt_timer_set.sv
// One 16-bit single timer plus four timer pairs, registers on an AXI4-Lite slave.
// Assumes clock pins are asynchronous to clk_sys; idle/sleep flags come from the clock domain.
`timescale 1ns/1ps

// Notes on behaviour
// - Single timer: internal timer, synchronized counter, or unsynchronized external counter.
// - Single timer flags on period match, or on gate falling edge when gated.
// - Single timer keeps counting in idle unless idle stop set; in sleep only as unsynchronized external counter.
// - Control bit 15 runs the timer when one, halts it when zero.
// - Gate bit 6 ignored with external clock; enables gated accumulation otherwise.
// - Prescale bits 5-4 divide by 1, 8, 64 or 256.
// - Sync bit 2 synchronizes external clock; ignored with internal clock.
// - Clock source bit 1 picks pin rising edges, else internal clock.
// - Pairs run as two 16-bit timers or one 32-bit timer/counter.
// - Each pair member alone is a synchronous timer or counter.
// - Even timer bit 3 joins the pair into one 32-bit timer.
// - In 32-bit mode the even timer is the low word.
// - In 32-bit mode odd control is ignored; even control, clock, gate govern.
// - In 32-bit mode the event appears on the odd timer's line.
// - In 32-bit mode the period is odd period high, even period low.
// - In 32-bit mode odd count holds upper word, even count lower.
// - Even run bit starts the whole pair in 32-bit mode, else only itself.
// - Only the second and third timers feed capture/compare and DMA.
// - First pair triggers first converter, second pair the second converter.
module gpt_timer_set (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock and gate pins
   input wire logic single_timer_clock_pin,
   input wire logic [7:0] pair_timer_clock_pin,
   // Device power state
   input wire logic idle_mode,
   input wire logic sleep_mode,
   // Events to interrupt controller, converters, DMA, capture/compare
   output logic [8:0] timer_event,
   output logic [1:0] adc_trigger,
   output logic [1:0] dma_request,
   output logic [15:0] timebase_2_count,
   output logic [15:0] timebase_3_count
);

   gpt_pkg::gpt_state_s s_q;
   gpt_pkg::gpt_state_s s_d;

   // Helpers visible to the checks below
   logic [8:0] tick_c;
   logic [8:0] match_c;
   logic [8:0] run_c;
   logic wr_go;

   function automatic logic [7:0] ps_limit(input logic [1:0] code);
      unique case (code)
         2'h0: ps_limit = gpt_pkg::PS_LIM_1;
         2'h1: ps_limit = gpt_pkg::PS_LIM_8;
         2'h2: ps_limit = gpt_pkg::PS_LIM_64;
         2'h3: ps_limit = gpt_pkg::PS_LIM_256;
      endcase
   endfunction

   function automatic logic [15:0] con_mask(input logic [3:0] slot);
      if (slot == 4'h0) begin
         con_mask = gpt_pkg::MASK_SINGLE;
      end else if (slot[0]) begin
         con_mask = gpt_pkg::MASK_EVEN;
      end else begin
         con_mask = gpt_pkg::MASK_ODD;
      end
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a[11:8] == 4'h0) && (a[7:4] <= gpt_pkg::LAST_TIMER) && (a[3:2] != 2'h3);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      merge = old;
      if (strb[0]) begin
         merge[7:0] = d[7:0];
      end
      if (strb[1]) begin
         merge[15:8] = d[15:8];
      end
   endfunction

   always_comb begin
      logic [8:0] rise;
      logic [8:0] fall;
      logic [15:0] c;
      logic [7:0] lim;
      logic slave;
      logic is_async;
      logic src;
      logic gated;
      logic wide;
      logic m;
      logic [31:0] nxt;
      logic [3:0] slot;
      logic [1:0] rsel;
      int lo;
      int hi;
      rise = '0;
      fall = '0;
      c = '0;
      lim = '0;
      slave = 1'b0;
      is_async = 1'b0;
      src = 1'b0;
      gated = 1'b0;
      wide = 1'b0;
      slot = '0;
      rsel = '0;
      lo = 0;
      hi = 0;
      s_d = s_q;
      tick_c = '0;
      match_c = '0;
      run_c = '0;
      wr_go = 1'b0;
      m = 1'b0;
      nxt = '0;
      // Pins pass three flops; only the second and later stages are looked at
      s_d.pin_s1 = {pair_timer_clock_pin, single_timer_clock_pin};
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_d = s_q.pin_s2;
      rise = s_q.pin_s2 & ~s_q.pin_d;
      fall = ~s_q.pin_s2 & s_q.pin_d;
      s_d.evt = '0;
      for (int i = 0; i < gpt_pkg::NUM_TIMERS; i++) begin
         lo = (i > 0) ? i - 1 : 0;
         hi = (i < 8) ? i + 1 : 8;
         c = s_q.con[i];
         slave = (i > 0) && (i % 2 == 0) && s_q.con[lo][gpt_pkg::BIT_PAIR];
         wide = (i % 2 == 1) && c[gpt_pkg::BIT_PAIR];
         // Only the single timer may run from an unsynchronized pin, so only it counts in sleep
         is_async = (i == 0) && c[gpt_pkg::BIT_CSRC] && !c[gpt_pkg::BIT_SYNC];
         run_c[i] = c[gpt_pkg::BIT_RUN] && !slave
                    && !(idle_mode && c[gpt_pkg::BIT_IDLE_STOP])
                    && !(sleep_mode && !is_async);
         gated = c[gpt_pkg::BIT_GATE] && !c[gpt_pkg::BIT_CSRC];
         src = c[gpt_pkg::BIT_CSRC] ? rise[i] : (!gated || s_q.pin_s2[i]);
         lim = ps_limit(c[gpt_pkg::BIT_PS_HI:gpt_pkg::BIT_PS_LO]);
         if (!run_c[i]) begin
            s_d.pre[i] = '0;
         end else if (src) begin
            tick_c[i] = (s_q.pre[i] == lim);
            s_d.pre[i] = tick_c[i] ? '0 : s_q.pre[i] + 8'h01;
         end
         // Gated mode flags on the gate's falling edge instead of on match
         if (run_c[i] && gated && fall[i]) begin
            s_d.evt[wide ? hi : i] = 1'b1;
         end
         if (tick_c[i] && wide) begin
            m = {s_q.cnt[hi], s_q.cnt[i]} == {s_q.per[hi], s_q.per[i]};
            nxt = m ? '0 : {s_q.cnt[hi], s_q.cnt[i]} + 32'h0000_0001;
            s_d.cnt[i] = nxt[15:0];
            s_d.cnt[hi] = nxt[31:16];
            match_c[i] = m;
            if (m && !gated) begin
               s_d.evt[hi] = 1'b1;
            end
         end else if (tick_c[i]) begin
            m = s_q.cnt[i] == s_q.per[i];
            s_d.cnt[i] = m ? '0 : s_q.cnt[i] + 16'h0001;
            match_c[i] = m;
            if (m && !gated) begin
               s_d.evt[i] = 1'b1;
            end
         end
      end
      // Write channel: address and data taken independently, acted on when both held
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_v = 1'b1;
         s_d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_v = 1'b1;
         s_d.w_d = s_axi_wdata;
         s_d.w_s = s_axi_wstrb;
      end
      if (s_q.aw_v && s_q.w_v) begin
         wr_go = 1'b1;
         slot = s_q.aw_a[7:4];
         rsel = s_q.aw_a[3:2];
         s_d.aw_v = 1'b0;
         s_d.w_v = 1'b0;
         s_d.b_v = 1'b1;
         s_d.b_r = addr_ok(s_q.aw_a) ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
         // Software writes win over the count update of the same cycle
         if (addr_ok(s_q.aw_a)) begin
            unique case (rsel)
               gpt_pkg::REG_CON: begin
                  s_d.con[slot] = merge(s_q.con[slot], s_q.w_d, s_q.w_s) & con_mask(slot);
                  s_d.pre[slot] = '0;
               end
               gpt_pkg::REG_CNT: s_d.cnt[slot] = merge(s_q.cnt[slot], s_q.w_d, s_q.w_s);
               gpt_pkg::REG_PER: s_d.per[slot] = merge(s_q.per[slot], s_q.w_d, s_q.w_s);
               default: s_d.b_r = gpt_pkg::RESP_SLVERR;
            endcase
         end
      end
      if (s_q.b_v && s_axi_bready) begin
         s_d.b_v = 1'b0;
      end
      // Read channel: answer one cycle after the address is taken
      if (s_q.r_v && s_axi_rready) begin
         s_d.r_v = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         slot = s_axi_araddr[7:4];
         rsel = s_axi_araddr[3:2];
         s_d.r_v = 1'b1;
         s_d.r_d = '0;
         s_d.r_r = gpt_pkg::RESP_SLVERR;
         if (addr_ok(s_axi_araddr)) begin
            s_d.r_r = gpt_pkg::RESP_OKAY;
            unique case (rsel)
               gpt_pkg::REG_CON: s_d.r_d = {16'h0000, s_q.con[slot]};
               gpt_pkg::REG_CNT: s_d.r_d = {16'h0000, s_q.cnt[slot]};
               gpt_pkg::REG_PER: s_d.r_d = {16'h0000, s_q.per[slot]};
               default: s_d.r_r = gpt_pkg::RESP_SLVERR;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.con <= {gpt_pkg::NUM_TIMERS{gpt_pkg::CON_RST}};
         s_q.cnt <= {gpt_pkg::NUM_TIMERS{gpt_pkg::CNT_RST}};
         s_q.per <= {gpt_pkg::NUM_TIMERS{gpt_pkg::PER_RST}};
      end else begin
         s_q <= s_d;
      end
   end

   // One write and one read under way at a time
   assign s_axi_awready = !s_q.aw_v && !s_q.b_v;
   assign s_axi_wready = !s_q.w_v && !s_q.b_v;
   assign s_axi_bvalid = s_q.b_v;
   assign s_axi_bresp = s_q.b_r;
   assign s_axi_arready = !s_q.r_v;
   assign s_axi_rvalid = s_q.r_v;
   assign s_axi_rdata = s_q.r_d;
   assign s_axi_rresp = s_q.r_r;

   assign timer_event = s_q.evt;
   // Converter triggers come from the odd member, which also carries the event in 32-bit mode
   assign adc_trigger = {s_q.evt[gpt_pkg::SLOT_T5], s_q.evt[gpt_pkg::SLOT_T3]};
   assign dma_request = {s_q.evt[gpt_pkg::SLOT_T3], s_q.evt[gpt_pkg::SLOT_T2]};
   assign timebase_2_count = s_q.cnt[gpt_pkg::SLOT_T2];
   assign timebase_3_count = s_q.cnt[gpt_pkg::SLOT_T3];

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   property p_halt;
      !s_q.con[0][gpt_pkg::BIT_RUN] && !wr_go |=> $stable(s_q.cnt[0]);
   endproperty
   a_halt: assert property (p_halt) else $error("stopped timer changed its count");

   property p_idle_stop;
      idle_mode && s_q.con[0][gpt_pkg::BIT_IDLE_STOP] && !wr_go |=> $stable(s_q.cnt[0]);
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("timer counted while idle stop");

   property p_match_wrap;
      tick_c[0] && match_c[0] && !wr_go |=> s_q.cnt[0] == 16'h0000;
   endproperty
   a_match_wrap: assert property (p_match_wrap) else $error("count not zero after match");

   property p_match_event;
      tick_c[0] && match_c[0] && !s_q.con[0][gpt_pkg::BIT_GATE] |=> timer_event[0];
   endproperty
   a_match_event: assert property (p_match_event) else $error("no event on period match");

   property p_ext_edge;
      s_q.con[0][gpt_pkg::BIT_CSRC] && !(s_q.pin_s2[0] && !s_q.pin_d[0]) && !wr_go
         |=> $stable(s_q.cnt[0]);
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("external count without pin edge");

   property p_prescale;
      run_c[0] && !s_q.con[0][gpt_pkg::BIT_CSRC] && !s_q.con[0][gpt_pkg::BIT_GATE]
         && s_q.con[0][gpt_pkg::BIT_PS_HI:gpt_pkg::BIT_PS_LO] == 2'h1 && s_q.pre[0] == 8'h00
         && !wr_go |=> !tick_c[0] [*6];
   endproperty
   a_prescale: assert property (p_prescale) else $error("1:8 prescaler ticked early");

   property p_pair_event;
      s_q.con[1][gpt_pkg::BIT_PAIR] && $past(s_q.con[1][gpt_pkg::BIT_PAIR]) |-> !timer_event[1];
   endproperty
   a_pair_event: assert property (p_pair_event) else $error("even member flagged in pair mode");

   property p_carry;
      s_q.con[1][gpt_pkg::BIT_PAIR] && tick_c[1] && !match_c[1] && s_q.cnt[1] == 16'hFFFF
         && !wr_go |=> s_q.cnt[2] == $past(s_q.cnt[2]) + 16'h0001 && s_q.cnt[1] == 16'h0000;
   endproperty
   a_carry: assert property (p_carry) else $error("low word wrap did not carry");

   property p_odd_slaved;
      s_q.con[1][gpt_pkg::BIT_PAIR] && !s_q.con[1][gpt_pkg::BIT_RUN] && !wr_go
         |=> $stable(s_q.cnt[2]) && $stable(s_q.cnt[1]);
   endproperty
   a_odd_slaved: assert property (p_odd_slaved) else $error("stopped pair still counting");

   property p_reserved;
      (s_q.con[0] & ~gpt_pkg::MASK_SINGLE) == 16'h0000
         && (s_q.con[1] & ~gpt_pkg::MASK_EVEN) == 16'h0000
         && (s_q.con[2] & ~gpt_pkg::MASK_ODD) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("unimplemented control bit set");

   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   property p_wr_resp;
      s_q.aw_v && s_q.w_v |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write response after both halves");

   property p_rd_err;
      s_axi_arvalid && s_axi_arready && !addr_ok(s_axi_araddr)
         |=> s_axi_rresp == gpt_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");

   property p_sleep_stop;
      sleep_mode && !(s_q.con[0][gpt_pkg::BIT_CSRC] && !s_q.con[0][gpt_pkg::BIT_SYNC])
         && !wr_go |=> $stable(s_q.cnt[0]);
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("timer counted during sleep");

   property p_gate_low;
      s_q.con[0][gpt_pkg::BIT_GATE] && !s_q.con[0][gpt_pkg::BIT_CSRC] && !s_q.pin_s2[0]
         && !wr_go |=> $stable(s_q.cnt[0]);
   endproperty
   a_gate_low: assert property (p_gate_low) else $error("gated timer counted with gate low");

   property p_pair_count;
      s_q.con[1][gpt_pkg::BIT_PAIR] && !tick_c[1] && !wr_go |=> $stable(s_q.cnt[2]);
   endproperty
   a_pair_count: assert property (p_pair_count) else $error("high word moved on its own");

   c_match: cover property (tick_c[0] && match_c[0]);
   c_pair_wrap: cover property (s_q.con[1][gpt_pkg::BIT_PAIR] && match_c[1]);
   c_gate_fall: cover property (timer_event[0] && s_q.con[0][gpt_pkg::BIT_GATE]);
   c_sleep_tick: cover property (sleep_mode && tick_c[0]);
   c_ext_tick: cover property (s_q.con[7][gpt_pkg::BIT_CSRC] && tick_c[7]);

endmodule

// ===== shared/gpt_pkg.sv
// Constants, register layout and state type of the general purpose timer set.
// Assumes one 40 MHz system clock; all users refer to names as gpt_pkg::name.
package gpt_pkg;

   // Timer slots: 0 is the single timer, 1..8 are the pair members (odd slot = even member)
   localparam int NUM_TIMERS = 9;
   localparam logic [3:0] LAST_TIMER = 4'h8;
   localparam int SLOT_T2 = 1;
   localparam int SLOT_T3 = 2;
   localparam int SLOT_T5 = 4;

   // Register word index inside one timer's 16-byte block (byte address = slot*16 + index*4)
   localparam logic [1:0] REG_CON = 2'h0;
   localparam logic [1:0] REG_CNT = 2'h1;
   localparam logic [1:0] REG_PER = 2'h2;
   localparam int ADDR_W = 12;

   // Control field positions
   localparam int BIT_RUN = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_GATE = 6;
   localparam int BIT_PS_HI = 5;
   localparam int BIT_PS_LO = 4;
   localparam int BIT_PAIR = 3;
   localparam int BIT_SYNC = 2;
   localparam int BIT_CSRC = 1;

   // Implemented control bits per kind of timer
   localparam logic [15:0] MASK_SINGLE = 16'hA076;
   localparam logic [15:0] MASK_EVEN = 16'hA07A;
   localparam logic [15:0] MASK_ODD = 16'hA072;

   // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
   localparam logic [7:0] PS_LIM_1 = 8'h00;
   localparam logic [7:0] PS_LIM_8 = 8'h07;
   localparam logic [7:0] PS_LIM_64 = 8'h3F;
   localparam logic [7:0] PS_LIM_256 = 8'hFF;

   // Reset values
   localparam logic [15:0] CON_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] PER_RST = 16'hFFFF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [8:0][15:0] con;
      logic [8:0][15:0] cnt;
      logic [8:0][15:0] per;
      logic [8:0][7:0] pre;
      logic [8:0] pin_s1;
      logic [8:0] pin_s2;
      logic [8:0] pin_d;
      logic [8:0] evt;
      logic aw_v;
      logic [11:0] aw_a;
      logic w_v;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic b_v;
      logic [1:0] b_r;
      logic r_v;
      logic [31:0] r_d;
      logic [1:0] r_r;
   } gpt_state_s;

endpackage

// ===== testbench/gpt_pin_model.sv
// Behavioural source for the clock and gate pins of the timer set.
// Assumes commands arrive on clk_sys edges; pins stand still between bursts.
`timescale 1ns/1ps
module gpt_pin_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Command from the bench
   input wire logic go,
   input wire logic [3:0] pin_sel,
   input wire logic [7:0] edges,
   input wire logic [7:0] half,
   input wire logic level,
   output logic busy,
   // Pins toward the timer set
   output logic single_timer_clock_pin,
   output logic [7:0] pair_timer_clock_pin
);
   logic [8:0] pins_q;
   logic [3:0] sel_q;
   logic [8:0] tog_q;
   logic [7:0] hc_q;
   assign single_timer_clock_pin = pins_q[0];
   assign pair_timer_clock_pin = pins_q[8:1];
   // Zero edges means a plain level change, used as a gate
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pins_q <= 9'h000;
         sel_q <= 4'h0;
         tog_q <= 9'h000;
         hc_q <= 8'h00;
         busy <= 1'b0;
      end else if (go && !busy) begin
         sel_q <= pin_sel;
         if (edges == 8'h00) begin
            pins_q[pin_sel] <= level;
         end else begin
            busy <= 1'b1;
            tog_q <= {edges, 1'b0};
            hc_q <= half;
         end
      end else if (busy) begin
         if (hc_q == 8'h01) begin
            pins_q[sel_q] <= ~pins_q[sel_q];
            tog_q <= tog_q - 9'h001;
            hc_q <= half;
            busy <= (tog_q != 9'h001);
         end else begin
            hc_q <= hc_q - 8'h01;
         end
      end
   end
endmodule

// ===== testbench/gpt_timer_set_tb.sv
// Self-checking bench for the timer set: AXI4-Lite master tasks plus pin model.
// Assumes the register map slot*0x10 + word*4 and one-cycle event pulses.
`timescale 1ns/1ps
module gpt_timer_set_tb;
   logic clk_sys, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, d2;
   logic [3:0] s_axi_wstrb, pin_sel;
   logic [1:0] s_axi_bresp, s_axi_rresp, adc_trigger, dma_request, r;
   logic single_timer_clock_pin, idle_mode, sleep_mode, go, level, busy, pair_on;
   logic bad_evt = 1'b0;
   logic [7:0] pair_timer_clock_pin, edges, half;
   logic [8:0] timer_event;
   logic [15:0] timebase_2_count, timebase_3_count;
   int num_errors = 0;
   int checks = 0;
   int s, c, p, n, e, k;

   gpt_timer_set dut_u (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .single_timer_clock_pin,
      .pair_timer_clock_pin, .idle_mode, .sleep_mode, .timer_event, .adc_trigger,
      .dma_request, .timebase_2_count, .timebase_3_count);
   gpt_pin_model pin_u (.clk_sys, .resetn, .go, .pin_sel, .edges, .half, .level, .busy,
      .single_timer_clock_pin, .pair_timer_clock_pin);

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic stop_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic int div(input int code);
      return (code == 0) ? 1 : (code == 1) ? 8 : (code == 2) ? 64 : 256;
   endfunction

   function automatic logic [15:0] mask(input int slot);
      if (slot == 0) return gpt_pkg::MASK_SINGLE;
      return (slot % 2) ? gpt_pkg::MASK_EVEN : gpt_pkg::MASK_ODD;
   endfunction

   // Address and data are offered together; each is released once taken
   // No wait limit of its own: a hung transfer is ended by the watchdog
   task automatic axi_wr(input logic [11:0] a, input logic [15:0] v, output logic [1:0] rsp);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, v};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      // The response may only follow once both halves were taken
      chk({31'h0, s_axi_awvalid | s_axi_wvalid}, 32'h0);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk({31'h0, s_axi_arvalid}, 32'h0);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input int slot, input int w, input logic [15:0] v);
      logic [1:0] rsp;
      axi_wr(12'(slot * 16 + w * 4), v, rsp);
      chk({30'h0, rsp}, {30'h0, gpt_pkg::RESP_OKAY});
   endtask

   task automatic rd(input int slot, input int w, output logic [31:0] v);
      logic [1:0] rsp;
      axi_rd(12'(slot * 16 + w * 4), v, rsp);
      chk({30'h0, rsp}, {30'h0, gpt_pkg::RESP_OKAY});
   endtask

   // Counts edges up to and including the next sampled event of one slot
   task automatic wait_evt(input int slot, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk_sys);
         cnt++;
      end while (timer_event[slot] !== 1'b1 && cnt < lim);
      if (cnt >= lim) chk(32'h0, 32'h1);
   endtask

   task automatic pin_cmd(input int slot, input int ne, input logic lv);
      pin_sel <= 4'(slot);
      edges <= 8'(ne);
      level <= lv;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (int t = 0; t < 200 && ne > 0; t++) begin
         @(posedge clk_sys);
         if (busy === 1'b0) break;
      end
   endtask

   // The even member must stay silent while its pair runs joined
   always @(posedge clk_sys) begin
      if (pair_on && timer_event[1] === 1'b1) bad_evt <= 1'b1;
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      stop_test();
   end

   initial begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {idle_mode, sleep_mode, go, level, pair_on} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      pin_sel = 4'h0;
      edges = 8'h00;
      half = 8'h04;
      void'($urandom(32'hBB6B));
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      for (s = 0; s < 9; s++) begin
         rd(s, 0, d);
         chk(d, 32'h0);
         rd(s, 1, d);
         chk(d, 32'h0);
         rd(s, 2, d);
         chk(d, {16'h0, gpt_pkg::PER_RST});
         wr(s, 0, 16'hFFFF);
         rd(s, 0, d);
         chk(d, {16'h0, mask(s)});
         wr(s, 0, 16'h0000);
      end
      axi_rd(12'h090, d, r);
      chk({30'h0, r}, {30'h0, gpt_pkg::RESP_SLVERR});
      chk(d, 32'h0);
      axi_wr(12'h00C, 16'hFFFF, r);
      chk({30'h0, r}, {30'h0, gpt_pkg::RESP_SLVERR});
      for (c = 0; c < 4; c++) begin
         s = $urandom_range(8);
         p = $urandom_range(4, 1);
         wr(s, 2, 16'(p));
         wr(s, 1, 16'h0000);
         wr(s, 0, 16'h8000 | 16'(c << 4));
         wait_evt(s, 3000, n);
         wait_evt(s, 3000, n);
         chk(32'(n), 32'((p + 1) * div(c)));
         chk({28'h0, adc_trigger, dma_request}, 32'({s == 4, s == 2, s == 2, s == 1}));
         wr(s, 0, 16'h0000);
         rd(s, 1, d);
         repeat (10) @(posedge clk_sys);
         rd(s, 1, d2);
         chk(d2, d);
      end
      wr(5, 2, 16'hFFFF);
      wr(5, 0, 16'hA000);
      idle_mode <= 1'b1;
      rd(5, 1, d);
      repeat (10) @(posedge clk_sys);
      rd(5, 1, d2);
      chk(d2, d);
      wr(5, 0, 16'h8000);
      rd(5, 1, d);
      repeat (10) @(posedge clk_sys);
      rd(5, 1, d2);
      chk(32'(d2 != d), 32'h1);
      idle_mode <= 1'b0;
      wr(5, 0, 16'h0000);
      for (k = 0; k < 2; k++) begin
         s = k ? 7 : 0;
         e = $urandom_range(9, 2);
         wr(s, 1, 16'h0000);
         wr(s, 2, 16'hFFFF);
         wr(s, 0, k ? 16'h8042 : (16'h8002 | 16'($urandom_range(1) << 2)));
         pin_cmd(s, e, 1'b0);
         repeat (8) @(posedge clk_sys);
         rd(s, 1, d);
         chk(d, 32'(e));
         wr(s, 0, 16'h0000);
      end
      sleep_mode <= 1'b1;
      wr(0, 1, 16'h0000);
      wr(0, 0, 16'h8002);
      pin_cmd(0, 3, 1'b0);
      repeat (8) @(posedge clk_sys);
      rd(0, 1, d);
      chk(d, 32'h3);
      wr(0, 0, 16'h8000);
      rd(0, 1, d);
      repeat (10) @(posedge clk_sys);
      rd(0, 1, d2);
      chk(d2, d);
      sleep_mode <= 1'b0;
      wr(0, 0, 16'h0000);
      wr(0, 1, 16'h0000);
      wr(0, 0, 16'h8040);
      pin_cmd(0, 0, 1'b1);
      repeat (19) @(posedge clk_sys);
      pin_cmd(0, 0, 1'b0);
      wait_evt(0, 10, n);
      rd(0, 1, d);
      chk(d, 32'd20);
      wr(0, 0, 16'h0000);
      pair_on <= 1'b1;
      wr(2, 2, 16'h0001);
      wr(1, 2, 16'h0030);
      wr(1, 1, 16'hFFF0);
      wr(2, 1, 16'h0000);
      wr(1, 0, 16'h8008);
      wr(2, 0, 16'h0000);
      repeat (20) @(posedge clk_sys);
      wr(1, 0, 16'h0000);
      rd(2, 1, d);
      chk(d, 32'h1);
      chk({16'h0, timebase_3_count}, d);
      rd(1, 1, d);
      chk({16'h0, timebase_2_count}, d);
      wr(1, 0, 16'h8008);
      wait_evt(2, 80, n);
      chk({30'h0, adc_trigger[0], dma_request[1]}, 32'h3);
      wr(1, 0, 16'h0000);
      pair_on <= 1'b0;
      chk({31'h0, bad_evt}, 32'h0);
      stop_test();
   end
endmodule
